/* File: hdl/magnet_io_pkg.sv */
// Constants, encodings and factory defaults of the magnet I/O setup block.
// Assumes a single system clock and fixed-point settings from the keypad.
package magnet_io_pkg;

  // ==========================================================================
  // Analog input formats
  typedef enum logic [1:0] {
    fmt_0_10v   = 2'h0,
    fmt_bipolar = 2'h1,
    fmt_4_20ma  = 2'h2
  } ain_format_t;

  // ==========================================================================
  // Monitor sources, programmable input functions and link settings
  typedef enum logic [1:0] {
    mon_magnet_current = 2'h0,
    mon_line_voltage   = 2'h1,
    mon_magnet_voltage = 2'h2
  } mon_source_t;

  typedef enum logic [2:0] {
    pin_unused      = 3'h0,
    pin_cur_reduce  = 3'h1,
    pin_dec_lift    = 3'h2,
    pin_fault_major = 3'h3,
    pin_fault_minor = 3'h4,
    pin_fault_reset = 3'h5,
    pin_over_temp   = 3'h6,
    pin_hoist_byp   = 3'h7
  } prog_input_function_t;

  typedef enum logic [1:0] {
    baud_2400  = 2'h0,
    baud_4800  = 2'h1,
    baud_9600  = 2'h2,
    baud_19200 = 2'h3
  } baud_t;

  typedef enum logic [1:0] {
    frame_8e1 = 2'h0,
    frame_8o1 = 2'h1,
    frame_8n1 = 2'h2,
    frame_8n2 = 2'h3
  } frame_t;

  typedef enum logic [1:0] {
    spec_unused = 2'h0,
    spec_multi  = 2'h1,
    spec_step   = 2'h2
  } speed_input_special_function_t;

  typedef enum logic [1:0] {
    rst_disabled = 2'h0,
    rst_fault_no = 2'h1,
    rst_fault_nc = 2'h2
  } reset_func_t;

  typedef enum logic [1:0] {
    en_unused  = 2'h0,
    en_drive   = 2'h1,
    en_battery = 2'h2
  } enable_func_t;

  typedef enum logic [3:0] {
    out_ready    = 4'h0,
    out_fault    = 4'h1,
    out_alarm    = 4'h2,
    out_lift     = 4'h3,
    out_hold     = 4'h4,
    out_drop     = 4'h5,
    out_agree    = 4'h6,
    out_pwr_loss = 4'h7,
    out_battery  = 4'h8
  } out_func_t;

  // ==========================================================================
  // Field limits (gain in 0.01, bias in 0.1 percent units)
  localparam logic [10:0] gain_unity    = 11'h064;
  localparam logic [10:0] gain_max      = 11'h3e8;
  localparam logic [10:0] bias1_max     = 11'h064;
  localparam logic [10:0] bias_wide_max = 11'h3e8;
  localparam logic [15:0] full_scale    = 16'h03e8;
  localparam logic [15:0] sat_max       = 16'h7fff;
  localparam logic [7:0]  gain_shift    = 8'h64;

endpackage

/* File: hdl/gain_bias.sv */
// Fixed-point gain and bias stage used by the analog paths.
// Assumes signed 0.1 percent samples and a gain in 0.01 steps.
`timescale 1ns/1ps
module gain_bias
  import magnet_io_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic signed [15:0] sample,
  input  wire logic        [10:0] gain,
  input  wire logic signed [11:0] bias,
  output logic signed      [15:0] result_reg
);

  logic signed [28:0] product;
  logic signed [28:0] sum;
  logic signed [15:0] result_next;

  always_comb
  begin
    product = (sample * $signed({1'b0, gain})) / $signed({1'b0, gain_shift});
    sum = product + bias;
    if (sum > $signed({13'h0, sat_max}))
      result_next = $signed(sat_max);
    else if (sum < -$signed({13'h0, sat_max}))
      result_next = -$signed(sat_max);
    else
      result_next = sum[15:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      result_reg <= 16'sh0000;
    else if (ce)
      result_reg <= result_next;
  end

endmodule

/* File: hdl/magnet_io_config.sv */
// I/O configuration block of a lifting-magnet controller.
// Assumes analog samples are already digital and on the clk_sys domain.
// Notes on behaviour
// - Input 1 takes three formats, input 2 two; default unipolar.
// - Each analog input is multiplied by a 0.00 to 10.00 gain.
// - Signed bias added: input 1 within 10 percent, input 2 within 100.
// - Monitor output scaled by gain; gain three reaches full scale early.
// - Monitor output gets a signed bias up to 100 percent.
// - Monitor source: magnet current, line voltage or magnet voltage.
// - One function setting serves both high and low voltage input.
// - Current reduction lowers hold current, only in lift modes.
// - Decreased lift scales lift and hold current, only lift modes.
// - Major external fault, normally closed, shuts down and logs.
// - Minor external fault logs and blocks the next lift.
// - Fault reset clears a latch only once the fault is gone.
// - Overtemperature function flags magnet heat to logic and operator.
// - Hoist bypass skips remaining lift time into hold.
// - Serial rate selectable 2400 to 19200, default 19200.
// - Eight data bits with 8E1, 8O1, 8N1 or 8N2 framing.
// - Serial port set for point to point or multidrop.
// - Speed inputs special function: unused, multi-magnet, stepped.
// - Reset input disabled, or fault reset normally open or closed.
// - Enable input unused, drive enable, or battery backup.
// - Four programmable outputs each pick a status function.
// - Serial may hand control to hardware; return only by keypad.
// - Maintain clean stops clean on input open; else run full time.
`timescale 1ns/1ps
module magnet_io_config
  import magnet_io_pkg::*;
(
  input  wire logic                            clk_sys,
  input  wire logic                            rst_n,
  input  wire logic                            ce,
  input  wire logic                            cfg_we,
  input  wire logic                            serial_ctl_release,
  input  wire logic                            set_serial_control,
  input  wire ain_format_t                     ain1_format_in,
  input  wire ain_format_t                     ain2_format_in,
  input  wire logic [10:0]                     ain1_gain_in,
  input  wire logic [10:0]                     ain2_gain_in,
  input  wire logic [10:0]                     mon_gain_in,
  input  wire logic signed [11:0]              ain1_bias_in,
  input  wire logic signed [11:0]              ain2_bias_in,
  input  wire logic signed [11:0]              mon_bias_in,
  input  wire mon_source_t                     mon_source_in,
  input  wire prog_input_function_t            prog_input_function_in,
  input  wire baud_t                           baud_in,
  input  wire frame_t                          frame_in,
  input  wire logic                            multidrop_in,
  input  wire speed_input_special_function_t   speed_func_in,
  input  wire reset_func_t                     reset_func_in,
  input  wire enable_func_t                    enable_func_in,
  input  wire logic                            maintain_clean_input_in,
  input  wire out_func_t [3:0]                 out_func_in,
  input  wire logic signed [15:0]              ain1_sample,
  input  wire logic signed [15:0]              ain2_sample,
  input  wire logic signed [15:0]              magnet_current,
  input  wire logic signed [15:0]              line_voltage,
  input  wire logic signed [15:0]              magnet_voltage,
  input  wire logic                            prog_in_hv_pin,
  input  wire logic                            prog_in_lv_pin,
  input  wire logic                            reset_pin,
  input  wire logic                            enable_pin,
  input  wire logic                            clean_pin,
  input  wire logic                            lift_mode,
  input  wire logic                            hold_state,
  input  wire logic                            clean_state,
  input  wire logic                            clean_timer_done,
  input  wire logic                            fault_present,
  input  wire logic [8:0]                      status_in,
  output logic signed [15:0]                   ain1_cmd_reg,
  output logic signed [15:0]                   ain2_cmd_reg,
  output logic signed [15:0]                   mon_out_reg,
  output baud_t                                baud_reg,
  output frame_t                               frame_reg,
  output logic                                 multidrop_reg,
  output speed_input_special_function_t        speed_func_reg,
  output logic                                 serial_control_reg,
  output logic                                 cur_reduce_reg,
  output logic                                 dec_lift_reg,
  output logic                                 shutdown_reg,
  output logic                                 log_event_reg,
  output logic                                 lift_block_reg,
  output logic                                 fault_latch_reg,
  output logic                                 over_temp_reg,
  output logic                                 hoist_bypass_reg,
  output logic                                 lift_allowed_reg,
  output logic                                 battery_mode_reg,
  output logic                                 clean_run_reg,
  output logic [3:0]                           prog_out_reg
);

  // ==========================================================================
  // State record
  typedef struct packed {
    ain_format_t                   ain1_format;
    ain_format_t                   ain2_format;
    logic [10:0]                   ain1_gain;
    logic [10:0]                   ain2_gain;
    logic [10:0]                   mon_gain;
    logic signed [11:0]            ain1_bias;
    logic signed [11:0]            ain2_bias;
    logic signed [11:0]            mon_bias;
    mon_source_t                   mon_source;
    prog_input_function_t          pfunc;
    baud_t                         baud;
    frame_t                        frame;
    logic                          multidrop;
    speed_input_special_function_t speed_func;
    reset_func_t                   reset_func;
    enable_func_t                  enable_func;
    logic                          maintain_clean;
    logic [15:0]                   out_func;
    logic                          serial_control;
    logic [4:0]                    sync1;
    logic [4:0]                    sync2;
    logic                          prog_prev;
    logic                          cur_reduce;
    logic                          dec_lift;
    logic                          shutdown;
    logic                          log_event;
    logic                          lift_block;
    logic                          fault_latch;
    logic                          over_temp;
    logic                          hoist_bypass;
    logic                          lift_allowed;
    logic                          battery_mode;
    logic                          clean_run;
    logic signed [15:0]            mon_sel;
    logic signed [15:0]            ain1_clip;
    logic signed [15:0]            ain2_clip;
    logic [3:0]                    prog_out;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic   prog_act;
  logic   reset_act;
  logic   enable_act;
  logic   clean_act;
  logic   reset_raw;

  function automatic logic signed [11:0] clamp_bias(
    input logic signed [11:0] value,
    input logic        [10:0] limit
  );
    logic signed [11:0] lim;
    lim = $signed({1'b0, limit});
    if (value > lim)
      clamp_bias = lim;
    else if (value < -lim)
      clamp_bias = -lim;
    else
      clamp_bias = value;
  endfunction

  function automatic logic [10:0] clamp_gain(input logic [10:0] value);
    clamp_gain = (value > gain_max) ? gain_max : value;
  endfunction

  // Limit a sample to the range its format can carry.
  function automatic logic signed [15:0] clip_fmt(
    input logic signed [15:0] value,
    input ain_format_t        fmt
  );
    logic signed [15:0] fs;
    fs = $signed(full_scale);
    if (value > fs)
      clip_fmt = fs;
    else if (fmt != fmt_bipolar && value < 16'sh0000)
      clip_fmt = 16'sh0000;
    else if (value < -fs)
      clip_fmt = -fs;
    else
      clip_fmt = value;
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = {clean_pin, enable_pin, reset_pin,
                     prog_in_lv_pin, prog_in_hv_pin};
    st_next.sync2 = st_reg.sync1;
    prog_act = st_reg.sync2[0] | st_reg.sync2[1];
    reset_raw = st_reg.sync2[2];
    enable_act = st_reg.sync2[3];
    clean_act = st_reg.sync2[4];
    st_next.prog_prev = prog_act;
    if (cfg_we)
    begin
      // Input 2 has no bipolar format
      st_next.ain1_format = ain1_format_in;
      st_next.ain2_format = (ain2_format_in == fmt_bipolar) ?
                            fmt_0_10v : ain2_format_in;
      st_next.ain1_gain = clamp_gain(ain1_gain_in);
      st_next.ain2_gain = clamp_gain(ain2_gain_in);
      st_next.mon_gain = clamp_gain(mon_gain_in);
      st_next.ain1_bias = clamp_bias(ain1_bias_in, bias1_max);
      st_next.ain2_bias = clamp_bias(ain2_bias_in, bias_wide_max);
      st_next.mon_bias = clamp_bias(mon_bias_in, bias_wide_max);
      st_next.mon_source = mon_source_in;
      st_next.pfunc = prog_input_function_in;
      st_next.baud = baud_in;
      st_next.frame = frame_in;
      st_next.multidrop = multidrop_in;
      st_next.speed_func = speed_func_in;
      st_next.reset_func = reset_func_in;
      st_next.enable_func = enable_func_in;
      st_next.maintain_clean = maintain_clean_input_in;
      st_next.out_func = out_func_in;
    end
    if (cfg_we && set_serial_control)
      st_next.serial_control = 1'b1;
    else if (serial_ctl_release)
      st_next.serial_control = 1'b0;
    reset_act = (st_reg.reset_func == rst_fault_no) ? reset_raw :
                (st_reg.reset_func == rst_fault_nc) ? !reset_raw : 1'b0;
    st_next.cur_reduce = (st_reg.pfunc == pin_cur_reduce) && prog_act &&
                         lift_mode && hold_state;
    st_next.dec_lift = (st_reg.pfunc == pin_dec_lift) && prog_act &&
                       lift_mode;
    st_next.over_temp = (st_reg.pfunc == pin_over_temp) && prog_act;
    st_next.hoist_bypass = (st_reg.pfunc == pin_hoist_byp) && prog_act &&
                           !hold_state;
    st_next.log_event = 1'b0;
    // Reset only when fault is gone
    if (((st_reg.pfunc == pin_fault_reset && prog_act) || reset_act) &&
        !fault_present)
    begin
      st_next.fault_latch = 1'b0;
      st_next.shutdown = 1'b0;
      st_next.lift_block = 1'b0;
    end
    if (st_reg.pfunc == pin_fault_major && !prog_act)
    begin
      st_next.shutdown = 1'b1;
      st_next.fault_latch = 1'b1;
      st_next.log_event = !st_reg.shutdown;
    end
    if (st_reg.pfunc == pin_fault_minor && prog_act && !st_reg.prog_prev)
    begin
      st_next.lift_block = 1'b1;
      st_next.log_event = 1'b1;
    end
    st_next.lift_allowed = !st_next.shutdown && !st_next.lift_block &&
                           (st_reg.enable_func != en_drive || enable_act);
    st_next.battery_mode = st_reg.enable_func == en_battery;
    if (!clean_state || clean_timer_done)
      st_next.clean_run = 1'b0;
    else if (clean_act)
      st_next.clean_run = 1'b1;
    else if (st_reg.maintain_clean)
      st_next.clean_run = 1'b0;
    case (st_reg.mon_source)
      mon_line_voltage:   st_next.mon_sel = line_voltage;
      mon_magnet_voltage: st_next.mon_sel = magnet_voltage;
      default:            st_next.mon_sel = magnet_current;
    endcase
    st_next.ain1_clip = clip_fmt(ain1_sample, st_reg.ain1_format);
    st_next.ain2_clip = clip_fmt(ain2_sample, st_reg.ain2_format);
    for (int i = 0; i < 4; i++)
      st_next.prog_out[i] = status_in[st_reg.out_func[i*4 +: 4]];
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.ain1_gain <= gain_unity;
      st_reg.ain2_gain <= gain_unity;
      st_reg.mon_gain <= gain_unity;
      st_reg.baud <= baud_19200;
      st_reg.frame <= frame_8e1;
      st_reg.maintain_clean <= 1'b1;
      st_reg.out_func <= {out_pwr_loss, out_alarm, out_fault, out_ready};
      st_reg.lift_allowed <= 1'b1;
    end
    else if (ce)
      st_reg <= st_next;
  end

  gain_bias u_ain1 (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ce         (ce),
    .sample     (st_reg.ain1_clip),
    .gain       (st_reg.ain1_gain),
    .bias       (st_reg.ain1_bias),
    .result_reg (ain1_cmd_reg)
  );

  gain_bias u_ain2 (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ce         (ce),
    .sample     (st_reg.ain2_clip),
    .gain       (st_reg.ain2_gain),
    .bias       (st_reg.ain2_bias),
    .result_reg (ain2_cmd_reg)
  );

  gain_bias u_mon (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .ce         (ce),
    .sample     (st_reg.mon_sel),
    .gain       (st_reg.mon_gain),
    .bias       (st_reg.mon_bias),
    .result_reg (mon_out_reg)
  );

  assign baud_reg           = st_reg.baud;
  assign frame_reg          = st_reg.frame;
  assign multidrop_reg      = st_reg.multidrop;
  assign speed_func_reg     = st_reg.speed_func;
  assign serial_control_reg = st_reg.serial_control;
  assign cur_reduce_reg     = st_reg.cur_reduce;
  assign dec_lift_reg       = st_reg.dec_lift;
  assign shutdown_reg       = st_reg.shutdown;
  assign log_event_reg      = st_reg.log_event;
  assign lift_block_reg     = st_reg.lift_block;
  assign fault_latch_reg    = st_reg.fault_latch;
  assign over_temp_reg      = st_reg.over_temp;
  assign hoist_bypass_reg   = st_reg.hoist_bypass;
  assign lift_allowed_reg   = st_reg.lift_allowed;
  assign battery_mode_reg   = st_reg.battery_mode;
  assign clean_run_reg      = st_reg.clean_run;
  assign prog_out_reg       = st_reg.prog_out;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  major_shut_a: assert property (ce && st_reg.pfunc == pin_fault_major &&
    !st_reg.sync2[0] && !st_reg.sync2[1] |=> shutdown_reg)
    else $error("Major fault did not shut down.");
  reset_guard_a: assert property ($fell(fault_latch_reg) |->
    !$past(fault_present))
    else $error("Fault cleared while still present.");
  cur_reduce_a: assert property (cur_reduce_reg |->
    $past(lift_mode) && $past(hold_state))
    else $error("Current reduction outside hold.");
  dec_lift_a: assert property (dec_lift_reg |-> $past(lift_mode))
    else $error("Decreased lift outside lift modes.");
  minor_block_a: assert property (lift_block_reg |-> !lift_allowed_reg)
    else $error("Lift allowed while blocked.");
  ctl_return_a: assert property ($rose(serial_control_reg) |->
    $past(cfg_we) && $past(set_serial_control))
    else $error("Serial control without manual change.");
  hoist_byp_a: assert property (hoist_bypass_reg |->
    $past(st_reg.pfunc) == pin_hoist_byp)
    else $error("Bypass with wrong function.");
  ain2_fmt_a: assert property (st_reg.ain2_format != fmt_bipolar)
    else $error("Input 2 bipolar.");
  bias1_rng_a: assert property (st_reg.ain1_bias <= 12'sh064 &&
    st_reg.ain1_bias >= -12'sh064)
    else $error("Input 1 bias out of range.");
  clean_stop_a: assert property (ce && clean_run_reg &&
    st_reg.maintain_clean && !st_reg.sync2[4] |=> !clean_run_reg)
    else $error("Clean kept running after input opened.");

  shut_c: cover property (ce ##1 $rose(shutdown_reg));
  reset_c: cover property ($fell(fault_latch_reg));
  clean_c: cover property ($fell(clean_run_reg));
  serial_c: cover property ($fell(serial_control_reg));

endmodule

/* File: dv/operator_panel.sv */
// Operator switch model facing the magnet I/O block's discrete inputs.
// Assumes the bench commands switch closures in step with clk_sys.
`timescale 1ns/1ps
module operator_panel
(
  input  wire logic clk_sys,
  input  wire logic prog_close,
  input  wire logic use_lv,
  input  wire logic reset_press,
  output logic      prog_in_hv_pin = 1'b0,
  output logic      prog_in_lv_pin = 1'b0,
  output logic      reset_pin      = 1'b0
);
  // ==========================================================================
  // Switch contacts
  // one switch wired to either input
  always @(posedge clk_sys)
  begin
    prog_in_hv_pin <= prog_close & ~use_lv;
    prog_in_lv_pin <= prog_close & use_lv;
    reset_pin      <= reset_press;
  end
endmodule

/* File: dv/tb_magnet_io_config.sv */
// Self-checking bench for the magnet I/O configuration block.
// Assumes a 25 MHz clk_sys and the operator_panel switch model.
`timescale 1ns/1ps
module tb_magnet_io_config;
  import magnet_io_pkg::*;
  typedef struct {baud_t b; frame_t f; logic [10:0] g;
    logic signed [11:0] bi; logic signed [15:0] s, e;} row_t;
  logic clk_sys = 1'b0, rst_n, ce, cfg_we, serial_ctl_release;
  logic set_serial_control, multidrop_in, maintain_clean_input_in;
  logic enable_pin, clean_pin, lift_mode, hold_state, clean_state;
  logic clean_timer_done, fault_present, prog_close, use_lv, reset_press;
  logic prog_in_hv_pin, prog_in_lv_pin, reset_pin;
  logic [8:0] status_in;
  ain_format_t ain1_format_in, ain2_format_in;
  logic [10:0] ain1_gain_in, ain2_gain_in, mon_gain_in;
  logic signed [11:0] ain1_bias_in, ain2_bias_in, mon_bias_in;
  logic signed [15:0] ain1_sample, ain2_sample, magnet_current;
  logic signed [15:0] line_voltage, magnet_voltage;
  logic signed [15:0] ain1_cmd_reg, ain2_cmd_reg, mon_out_reg;
  mon_source_t mon_source_in;
  prog_input_function_t prog_input_function_in;
  baud_t baud_in, baud_reg;
  frame_t frame_in, frame_reg;
  speed_input_special_function_t speed_func_in, speed_func_reg;
  reset_func_t reset_func_in;
  enable_func_t enable_func_in;
  out_func_t [3:0] out_func_in;
  logic multidrop_reg, serial_control_reg, cur_reduce_reg, dec_lift_reg;
  logic shutdown_reg, log_event_reg, lift_block_reg, fault_latch_reg;
  logic over_temp_reg, hoist_bypass_reg, lift_allowed_reg;
  logic battery_mode_reg, clean_run_reg;
  logic [3:0] prog_out_reg;
  int miscompares = 0;
  int cmp_count = 0;
  int ev;
  prog_input_function_t fn[3] = '{pin_cur_reduce, pin_dec_lift,
                                  pin_over_temp};
  row_t rows[4] = '{
    '{baud_2400, frame_8o1, 11'h12c, 12'sh000, 16'sh03e8, 16'sh0bb8},
    '{baud_4800, frame_8n1, 11'h3e8, -12'sh032, 16'sh0064, 16'sh03b6},
    '{baud_9600, frame_8n2, 11'h4b0, 12'sh000, 16'sh000a, 16'sh0064},
    '{baud_19200, frame_8e1, 11'h064, 12'sh0c8, 16'sh0000, 16'sh0064}};

  always #20 clk_sys = ~clk_sys;

  magnet_io_config i_magnet_io_config (.clk_sys, .rst_n, .ce, .cfg_we,
    .serial_ctl_release, .set_serial_control, .ain1_format_in,
    .ain2_format_in, .ain1_gain_in, .ain2_gain_in, .mon_gain_in,
    .ain1_bias_in, .ain2_bias_in, .mon_bias_in, .mon_source_in,
    .prog_input_function_in, .baud_in, .frame_in, .multidrop_in,
    .speed_func_in, .reset_func_in, .enable_func_in,
    .maintain_clean_input_in, .out_func_in, .ain1_sample, .ain2_sample,
    .magnet_current, .line_voltage, .magnet_voltage, .prog_in_hv_pin,
    .prog_in_lv_pin, .reset_pin, .enable_pin, .clean_pin, .lift_mode,
    .hold_state, .clean_state, .clean_timer_done, .fault_present,
    .status_in, .ain1_cmd_reg, .ain2_cmd_reg, .mon_out_reg, .baud_reg,
    .frame_reg, .multidrop_reg, .speed_func_reg, .serial_control_reg,
    .cur_reduce_reg, .dec_lift_reg, .shutdown_reg, .log_event_reg,
    .lift_block_reg, .fault_latch_reg, .over_temp_reg, .hoist_bypass_reg,
    .lift_allowed_reg, .battery_mode_reg, .clean_run_reg, .prog_out_reg);

  operator_panel i_operator_panel (.clk_sys, .prog_close, .use_lv,
    .reset_press, .prog_in_hv_pin, .prog_in_lv_pin, .reset_pin);

  // ==========================================================================
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic cfg;
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
  endtask

  task automatic chk(input string n, input logic [15:0] e, g);
    cmp_count++;
    if (e !== g)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    miscompares++;
    finish_test();
  end

  // ==========================================================================
  // Main sequence
  initial
  begin
    {rst_n, ce, cfg_we, serial_ctl_release, set_serial_control} = 5'h08;
    {multidrop_in, maintain_clean_input_in, enable_pin, clean_pin} = 4'h4;
    {lift_mode, hold_state, clean_state, clean_timer_done} = 4'h0;
    {fault_present, prog_close, use_lv, reset_press} = 4'h0;
    {ain1_format_in, ain2_format_in} = {fmt_0_10v, fmt_0_10v};
    {ain1_gain_in, ain2_gain_in, mon_gain_in} = {3{11'h064}};
    {ain1_bias_in, ain2_bias_in, mon_bias_in} = '0;
    {ain1_sample, ain2_sample, magnet_current} = {16'sh01f4, 32'sh0};
    {line_voltage, magnet_voltage, status_in} = {32'sh0, 9'h081};
    {mon_source_in, prog_input_function_in} = {mon_magnet_current, pin_unused};
    {baud_in, frame_in, speed_func_in} = {baud_19200, frame_8e1, spec_unused};
    {reset_func_in, enable_func_in} = {rst_disabled, en_unused};
    out_func_in = {out_pwr_loss, out_alarm, out_fault, out_ready};
    cyc(20);
    rst_n = 1'b1;
    cyc(4);
    chk("baud", 16'(baud_19200), 16'(baud_reg));
    chk("frame", 16'(frame_8e1), 16'(frame_reg));
    chk("multidrop", 16'h0000, 16'(multidrop_reg));
    chk("speed", 16'(spec_unused), 16'(speed_func_reg));
    chk("outputs", 16'h0009, 16'(prog_out_reg));
    chk("ain1 unity", 16'h01f4, ain1_cmd_reg);
    chk("serial", 16'h0000, 16'(serial_control_reg));
    foreach (rows[i])
    begin
      {baud_in, frame_in, ain1_gain_in} = {rows[i].b, rows[i].f, rows[i].g};
      {ain1_bias_in, ain1_sample} = {rows[i].bi, rows[i].s};
      speed_func_in = speed_input_special_function_t'(i % 3);
      multidrop_in = i[0];
      cfg();
      cyc(3);
      chk("baud", 16'(rows[i].b), 16'(baud_reg));
      chk("frame", 16'(rows[i].f), 16'(frame_reg));
      chk("ain1", rows[i].e, ain1_cmd_reg);
      chk("speed", 16'(i % 3), 16'(speed_func_reg));
      chk("multidrop", 16'(i[0]), 16'(multidrop_reg));
    end
    {mon_source_in, mon_gain_in, line_voltage} = {mon_line_voltage, 11'h12c,
                                                  16'sh014d};
    {magnet_current, ain2_bias_in} = {16'sh0100, 12'sh7d0};
    cfg();
    cyc(3);
    chk("monitor", 16'h03e7, mon_out_reg);
    chk("ain2 bias", 16'h03e8, ain2_cmd_reg);
    {lift_mode, hold_state, prog_close} = 3'h7;
    for (int k = 0; k < 3; k++)
    begin
      prog_input_function_in = fn[k];
      use_lv = k[0];
      cfg();
      cyc(4);
      chk("func", 16'(3'h4 >> k),
          16'({cur_reduce_reg, dec_lift_reg, over_temp_reg}));
    end
    prog_input_function_in = pin_dec_lift;
    lift_mode = 1'b0;
    cfg();
    cyc(4);
    chk("dec lift gate", 16'h0000, 16'(dec_lift_reg));
    prog_input_function_in = pin_fault_major;
    cfg();
    cyc(4);
    chk("healthy", 16'h0000, 16'(shutdown_reg));
    {prog_close, fault_present, ev} = {2'h1, 32'h0};
    repeat (6)
    begin
      cyc(1);
      ev = ev + int'(log_event_reg);
    end
    chk("shutdown", 16'h0001, 16'(shutdown_reg));
    chk("latch", 16'h0001, 16'(fault_latch_reg));
    chk("log", 16'h0001, 16'(ev));
    {prog_close, reset_func_in, reset_press} = {1'b1, rst_fault_no, 1'b1};
    cfg();
    cyc(5);
    chk("latch held", 16'h0001, 16'(fault_latch_reg));
    fault_present = 1'b0;
    cyc(5);
    chk("latch clear", 16'h0000, 16'(fault_latch_reg));
    reset_press = 1'b0;
    set_serial_control = 1'b1;
    cfg();
    set_serial_control = 1'b0;
    cyc(1);
    chk("serial set", 16'h0001, 16'(serial_control_reg));
    serial_ctl_release = 1'b1;
    cyc(1);
    serial_ctl_release = 1'b0;
    cyc(1);
    chk("serial off", 16'h0000, 16'(serial_control_reg));
    {prog_close, hold_state, clean_state, clean_pin} = 4'h3;
    prog_input_function_in = pin_fault_minor;
    cfg();
    prog_close = 1'b1;
    cyc(3);
    prog_input_function_in = pin_hoist_byp;
    enable_func_in = en_battery;
    cfg();
    cyc(2);
    chk("flags", 16'h0017,
        16'({lift_block_reg, lift_allowed_reg, hoist_bypass_reg,
             battery_mode_reg, clean_run_reg}));
    clean_pin = 1'b0;
    cyc(3);
    chk("clean", 16'h0000, 16'(clean_run_reg));
    finish_test();
  end
endmodule
